// ---- include/qdc_pkg.sv ----
// Shared constants for the quad converter serial command port
package qdc_pkg;

    // ==================== Frame layout ====================
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned CNT_W      = 5;
    localparam int unsigned DATA_W     = 14;
    localparam int unsigned PD_W       = 2;
    localparam int unsigned ENTRY_W    = PD_W + DATA_W;
    localparam int unsigned N_CHAN     = 4;
    localparam int unsigned SEL_W      = 2;

    localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;

    // Field positions within the input shift register
    localparam int unsigned POS_ADDR_HI = 23;
    localparam int unsigned POS_ADDR_LO = 22;
    localparam int unsigned POS_LD_HI   = 21;
    localparam int unsigned POS_LD_LO   = 20;
    localparam int unsigned POS_SEL_HI  = 18;
    localparam int unsigned POS_SEL_LO  = 17;
    localparam int unsigned POS_PD_SEL  = 16;
    localparam int unsigned POS_DATA_HI = 15;
    localparam int unsigned POS_DATA_LO = 2;
    localparam int unsigned POS_PDM_LO  = 14;

    // ==================== Load control codes ====================
    localparam logic [1:0] LD_STORE  = 2'h0;
    localparam logic [1:0] LD_UPDATE = 2'h1;
    localparam logic [1:0] LD_SIMUL  = 2'h2;
    localparam logic [1:0] LD_BCAST  = 2'h3;

    localparam logic [PD_W-1:0]    PD_ACTIVE  = 2'h0;
    localparam logic [ENTRY_W-1:0] ENTRY_RST  = 16'h0000;

    // ==================== Reference command words ====================
    localparam logic [FRAME_BITS-1:0] CMD_REF_OFF  = 24'h012000;
    localparam logic [FRAME_BITS-1:0] CMD_REF_AUTO = 24'h010000;
    localparam logic [FRAME_BITS-1:0] CMD_REF_ON   = 24'h011000;

    typedef enum logic [1:0] {QDC_REF_AUTO, QDC_REF_OFF, QDC_REF_ON} qdc_ref_e;

    // ==================== Timing ====================
    localparam int unsigned CLK_NS        = 8;
    localparam int unsigned SCLK_NS       = 64;
    localparam int unsigned GAP_NS        = 100;
    localparam int unsigned LEAD_NS       = 32;
    localparam int unsigned HALF_CYC      = SCLK_NS / (2 * CLK_NS);
    localparam int unsigned GAP_CYC       = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned LEAD_CYC      = (LEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TMR_W         = 5;
    localparam logic [TMR_W-1:0] HALF_LAST = TMR_W'(HALF_CYC - 1);
    localparam logic [TMR_W-1:0] GAP_LAST  = TMR_W'(GAP_CYC - 1);
    localparam logic [TMR_W-1:0] LEAD_LAST = TMR_W'(LEAD_CYC - 1);

endpackage

// ---- include/qdc_if.sv ----
// Three-wire serial link between host and converter
`timescale 1ns/1ps
interface qdc_if;
    logic frame_sel_n;
    logic sclk;
    logic sdata;

    modport host (output frame_sel_n, output sclk, output sdata);
    modport dev  (input  frame_sel_n, input  sclk, input  sdata);
endinterface

// ---- hw/qdc_sync.sv ----
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module qdc_sync #(
    parameter int unsigned     W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    // ==================== Two-stage capture ====================
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// ---- hw/qdc_dev.sv ----
// Converter end: serial receiver, command decode, buffers and converter registers
// Operation
// - 24-bit shift register, MSB first
// - Sample data on each falling serial clock
// - Host drops frame select before data
// - Lock register after 24th bit
// - Execute right after 24th falling edge
// - Early frame select rise discards frame
// - New frame only on next select fall
// - Eight control bits, 14 data, two ignored
// - Data is straight binary code
// - Address bits must match address pins
// - Host always sends zero in DB19
// - Two select bits choose the channel
// - Power-down select picks data or power-down
// - Load code 00 stores buffer only
// - Load code 01 updates buffer and converter
// - Load code 10 loads all simultaneously
// - Load code 11 overrides address match
// - Broadcast DB18 zero loads from buffers
// - Broadcast DB18 one loads shifted data
// - Select 00..11 maps channels A..D
// - Three full words control the reference
// - Auto reference follows channel power states
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
module qdc_dev
    import qdc_pkg::*;
(
    input  wire logic                                  i_clk_sys,
    input  wire logic                                  i_rst_n,
    qdc_if.dev                                         link,
    input  wire logic                                  i_addr_pin_hi,
    input  wire logic                                  i_addr_pin_lo,
    output logic [qdc_pkg::N_CHAN*qdc_pkg::DATA_W-1:0] o_dac_code,
    output logic [qdc_pkg::N_CHAN*qdc_pkg::PD_W-1:0]   o_chan_pd,
    output logic                                       o_ref_on,
    output logic                                       o_cmd_exec
);
    import qdc_pkg::*;

    typedef enum logic [1:0] {QDC_IDLE, QDC_SHIFT, QDC_LOCKED} qdc_rx_e;

    // ==================== Pin synchronisers ====================
    logic [4:0] pins_s;
    logic       sel_n_s;
    logic       sclk_s;
    logic       sdata_s;
    logic       addr_hi_s;
    logic       addr_lo_s;

    qdc_sync #(.W(5), .RST_VAL(5'h10)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   ({link.frame_sel_n, link.sclk, link.sdata, i_addr_pin_hi, i_addr_pin_lo}),
        .o_sync    (pins_s)
    );

    assign sel_n_s   = pins_s[4];
    assign sclk_s    = pins_s[3];
    assign sdata_s   = pins_s[2];
    assign addr_hi_s = pins_s[1];
    assign addr_lo_s = pins_s[0];

    // ==================== Edge detection ====================
    logic sclk_prev_q;
    logic sel_n_prev_q;
    logic sclk_fall;
    logic sel_fall;
    logic sel_rise;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_prev_q  <= 1'b0;
            sel_n_prev_q <= 1'b1;
        end else begin
            sclk_prev_q  <= sclk_s;
            sel_n_prev_q <= sel_n_s;
        end
    end

    assign sclk_fall = sclk_prev_q & ~sclk_s;
    assign sel_fall  = sel_n_prev_q & ~sel_n_s;
    assign sel_rise  = ~sel_n_prev_q & sel_n_s;

    // ==================== Receive sequencer ====================
    qdc_rx_e                 st_q, st_d;
    logic [CNT_W-1:0]        cnt_q, cnt_d;
    logic [FRAME_BITS-1:0]   sr_q, sr_d;
    logic                    exec_q, exec_d;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        sr_d   = sr_q;
        exec_d = 1'b0;
        unique case (st_q)
            QDC_IDLE: begin
                if (sel_fall) begin
                    st_d  = QDC_SHIFT;
                    cnt_d = '0;
                end
            end
            QDC_SHIFT: begin
                if (sel_rise) begin
                    st_d = QDC_IDLE;
                end else if (sclk_fall) begin
                    sr_d  = {sr_q[FRAME_BITS-2:0], sdata_s};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == LAST_BIT) begin
                        st_d   = QDC_LOCKED;
                        exec_d = 1'b1;
                    end
                end
            end
            QDC_LOCKED: begin
                if (sel_rise) begin
                    st_d = QDC_IDLE;
                end
            end
        endcase
    end

    // Sequencer registers; reset returns link to idle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q   <= QDC_IDLE;
            cnt_q  <= '0;
            sr_q   <= '0;
            exec_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            sr_q   <= sr_d;
            exec_q <= exec_d;
        end
    end

    // ==================== Command decode ====================
    logic [1:0]        ld_code;
    logic [SEL_W-1:0]  chan_sel;
    logic              pd_sel;
    logic              addr_ok;
    logic              is_bcast;
    logic              is_ref_off;
    logic              is_ref_auto;
    logic              is_ref_on;
    logic              is_ref;
    logic              act;
    logic [ENTRY_W-1:0] new_entry_data;

    assign ld_code  = sr_q[POS_LD_HI:POS_LD_LO];
    assign chan_sel = sr_q[POS_SEL_HI:POS_SEL_LO];
    assign pd_sel   = sr_q[POS_PD_SEL];
    assign is_bcast = (ld_code == LD_BCAST);
    assign addr_ok  = (sr_q[POS_ADDR_HI] == addr_hi_s) &&
                      (sr_q[POS_ADDR_LO] == addr_lo_s);
    assign is_ref_off  = (sr_q == CMD_REF_OFF);
    assign is_ref_auto = (sr_q == CMD_REF_AUTO);
    assign is_ref_on   = (sr_q == CMD_REF_ON);
    assign is_ref      = is_ref_off | is_ref_auto | is_ref_on;
    assign act         = exec_q & ~is_ref & (addr_ok | is_bcast);
    // Data word: 14-bit straight binary, DB1..DB0 dropped, powers channel up
    assign new_entry_data = {PD_ACTIVE, sr_q[POS_DATA_HI:POS_DATA_LO]};

    // ==================== Per-channel storage ====================
    logic [ENTRY_W-1:0] buf_q [N_CHAN];
    logic [ENTRY_W-1:0] dac_q [N_CHAN];
    logic [N_CHAN-1:0]  chan_up;

    genvar gi;
    generate
        for (gi = 0; gi < N_CHAN; gi++) begin : g_chan
            logic               sel_hit;
            logic               buf_we;
            logic               dac_new;
            logic               dac_old;
            logic [ENTRY_W-1:0] new_entry;

            assign sel_hit   = (chan_sel == SEL_W'(gi));
            // Power-down frame keeps stored code, replaces the mode
            assign new_entry = pd_sel ? {sr_q[POS_DATA_HI:POS_PDM_LO], buf_q[gi][DATA_W-1:0]}
                                      : new_entry_data;
            assign buf_we    = act & (is_bcast ? sr_q[POS_SEL_HI] : sel_hit);
            assign dac_new   = act & (((ld_code == LD_UPDATE) & sel_hit) |
                                      ((ld_code == LD_SIMUL) & sel_hit) |
                                      (is_bcast & sr_q[POS_SEL_HI]));
            assign dac_old   = act & (((ld_code == LD_SIMUL) & ~sel_hit) |
                                      (is_bcast & ~sr_q[POS_SEL_HI]));
            assign chan_up[gi] = (dac_q[gi][ENTRY_W-1:DATA_W] == PD_ACTIVE);

            // Buffer and converter register of one channel
            always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    buf_q[gi] <= ENTRY_RST;
                    dac_q[gi] <= ENTRY_RST;
                end else begin
                    if (buf_we) begin
                        buf_q[gi] <= new_entry;
                    end
                    if (dac_new) begin
                        dac_q[gi] <= new_entry;
                    end else if (dac_old) begin
                        dac_q[gi] <= buf_q[gi];
                    end
                end
            end

            assign o_dac_code[gi*DATA_W +: DATA_W] = dac_q[gi][DATA_W-1:0];
            assign o_chan_pd[gi*PD_W +: PD_W]      = dac_q[gi][ENTRY_W-1:DATA_W];
        end
    endgenerate

    // ==================== Reference control ====================
    qdc_ref_e ref_mode_q;
    logic     ref_on_q;
    logic     ref_on_d;
    logic     exec_out_q;
    logic     ref_exec;

    // Reference words are commands too: unaddressed converters ignore them
    assign ref_exec = exec_q & addr_ok;
    assign ref_on_d = (ref_mode_q == QDC_REF_ON) |
                      ((ref_mode_q == QDC_REF_AUTO) & (|chan_up));

    // Reference mode, reference state and execute strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ref_mode_q <= QDC_REF_AUTO;
            ref_on_q   <= 1'b0;
            exec_out_q <= 1'b0;
        end else begin
            if (ref_exec & is_ref_off) begin
                ref_mode_q <= QDC_REF_OFF;
            end else if (ref_exec & is_ref_auto) begin
                ref_mode_q <= QDC_REF_AUTO;
            end else if (ref_exec & is_ref_on) begin
                ref_mode_q <= QDC_REF_ON;
            end
            ref_on_q   <= ref_on_d;
            exec_out_q <= act | (ref_exec & is_ref);
        end
    end

    assign o_ref_on   = ref_on_q;
    assign o_cmd_exec = exec_out_q;

endmodule

// ---- hw/qdc_host.sv ----
// Host end: sends one 24-bit command frame per start request
`timescale 1ns/1ps
module qdc_host
    import qdc_pkg::*;
(
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_rst_n,
    qdc_if.host                                 link,
    input  wire logic                           i_start,
    input  wire logic [qdc_pkg::FRAME_BITS-1:0] i_word,
    output logic                                o_busy,
    output logic                                o_done
);
    import qdc_pkg::*;

    typedef enum logic [2:0] {QDC_H_IDLE, QDC_H_LEAD, QDC_H_HIGH, QDC_H_LOW, QDC_H_TAIL, QDC_H_GAP} qdc_tx_e;

    qdc_tx_e               st_q, st_d;
    logic [TMR_W-1:0]      tmr_q, tmr_d;
    logic [CNT_W-1:0]      cnt_q, cnt_d;
    logic [FRAME_BITS-1:0] sr_q, sr_d;
    logic                  sel_n_q, sel_n_d;
    logic                  sclk_q, sclk_d;
    logic                  sdata_q, sdata_d;
    logic                  done_q, done_d;
    logic                  busy_d;
    logic                  busy_q;
    logic                  tmr_half;

    assign tmr_half = (tmr_q == HALF_LAST);

    // ==================== Transmit sequencer ====================
    always_comb begin
        st_d    = st_q;
        tmr_d   = tmr_q + 5'h01;
        cnt_d   = cnt_q;
        sr_d    = sr_q;
        sel_n_d = sel_n_q;
        sclk_d  = sclk_q;
        sdata_d = sdata_q;
        done_d  = 1'b0;
        unique case (st_q)
            QDC_H_IDLE: begin
                tmr_d = '0;
                if (i_start) begin
                    st_d    = QDC_H_LEAD;
                    sr_d    = i_word;
                    sel_n_d = 1'b0;
                end
            end
            QDC_H_LEAD: begin
                if (tmr_q == LEAD_LAST) begin
                    st_d    = QDC_H_HIGH;
                    tmr_d   = '0;
                    cnt_d   = '0;
                    sclk_d  = 1'b1;
                    sdata_d = sr_q[FRAME_BITS-1];
                end
            end
            QDC_H_HIGH: begin
                if (tmr_half) begin
                    st_d   = QDC_H_LOW;
                    tmr_d  = '0;
                    sclk_d = 1'b0;                       // Falling edge: far end samples
                end
            end
            QDC_H_LOW: begin
                if (tmr_half) begin
                    tmr_d = '0;
                    cnt_d = cnt_q + 5'h01;
                    sr_d  = {sr_q[FRAME_BITS-2:0], 1'b0};
                    if (cnt_q == LAST_BIT) begin
                        st_d    = QDC_H_TAIL;
                        sel_n_d = 1'b1;
                    end else begin
                        st_d    = QDC_H_HIGH;
                        sclk_d  = 1'b1;
                        sdata_d = sr_q[FRAME_BITS-2];
                    end
                end
            end
            QDC_H_TAIL: begin
                st_d  = QDC_H_GAP;
                tmr_d = '0;
            end
            QDC_H_GAP: begin
                if (tmr_q == GAP_LAST) begin
                    st_d   = QDC_H_IDLE;
                    done_d = 1'b1;
                end
            end
            default: begin
                st_d = QDC_H_IDLE;
            end
        endcase
    end

    assign busy_d = (st_d != QDC_H_IDLE);

    // Sequencer and pin registers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q    <= QDC_H_IDLE;
            tmr_q   <= '0;
            cnt_q   <= '0;
            sr_q    <= '0;
            sel_n_q <= 1'b1;
            sclk_q  <= 1'b0;
            sdata_q <= 1'b0;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            tmr_q   <= tmr_d;
            cnt_q   <= cnt_d;
            sr_q    <= sr_d;
            sel_n_q <= sel_n_d;
            sclk_q  <= sclk_d;
            sdata_q <= sdata_d;
            done_q  <= done_d;
            busy_q  <= busy_d;
        end
    end

    assign link.frame_sel_n = sel_n_q;
    assign link.sclk        = sclk_q;
    assign link.sdata       = sdata_q;
    assign o_busy           = busy_q;
    assign o_done           = done_q;

endmodule

// ---- dv/qdc_link_chk.sv ----
// Link and handshake checker for the host to converter serial port
`timescale 1ns/1ps
module qdc_link_chk
    import qdc_pkg::*;
(
    input wire logic                                  i_clk_sys,
    input wire logic                                  i_rst_n,
    input wire logic                                  frame_sel_n,
    input wire logic                                  sclk,
    input wire logic                                  sdata,
    input wire logic                                  o_busy,
    input wire logic                                  o_done,
    input wire logic                                  o_cmd_exec,
    input wire logic [qdc_pkg::N_CHAN*qdc_pkg::DATA_W-1:0] o_dac_code
);
    // ==================== Helper ====================
    logic [4:0] fall_cnt_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // Count falling clocks since the last select fall
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fall_cnt_q <= 5'h00;
        end else if ($fell(frame_sel_n)) begin
            fall_cnt_q <= 5'h00;
        end else if (!frame_sel_n && $fell(sclk) && fall_cnt_q != 5'h1f) begin
            fall_cnt_q <= fall_cnt_q + 5'h01;
        end
    end

    // ==================== Assertions ====================
    chk_exec_full_frame: assert property (o_cmd_exec |-> fall_cnt_q == 5'h18)
        else $error("command executed without 24 falling clocks");
    chk_frame_bits_24: assert property ($rose(frame_sel_n) |-> fall_cnt_q == 5'h18)
        else $error("frame closed with wrong bit count");
    chk_clk_in_frame: assert property ($fell(sclk) |-> !frame_sel_n)
        else $error("serial clock fell outside a frame");
    chk_clk_idle_low: assert property (frame_sel_n |-> !sclk)
        else $error("serial clock high while idle");
    chk_data_stable: assert property ($fell(sclk) |-> $stable(sdata))
        else $error("data moved at the sampling edge");
    chk_code_on_exec: assert property ($changed(o_dac_code) |-> o_cmd_exec)
        else $error("converter code changed without a command");
    chk_exec_one_pulse: assert property (o_cmd_exec |=> !o_cmd_exec)
        else $error("command pulse longer than one cycle");
    chk_select_gap: assert property ($rose(frame_sel_n) |=> frame_sel_n [*8])
        else $error("select fell too soon after a frame");
    chk_busy_to_done: assert property ($rose(o_busy) |-> ##[200:212] o_done)
        else $error("frame did not complete in time");
    chk_done_pulse: assert property (o_done |-> !o_busy ##1 !o_done)
        else $error("done not a single idle cycle");

    // ==================== Covers ====================
    cov_exec: cover property (o_cmd_exec);
    cov_frame_end: cover property ($rose(frame_sel_n));
    cov_back_to_back: cover property (o_done ##1 o_busy);
endmodule

// ---- dv/qdc_tb_top.sv ----
// Testbench: host end driving two converters, plus a rule-breaking link
`timescale 1ns/1ps
`define QDC_CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module qdc_tb_top;
    import qdc_pkg::*;
    logic                     clk_sys, rst_n, start, busy, done;
    logic [FRAME_BITS-1:0]    word;
    logic [N_CHAN*DATA_W-1:0] code_o [3];
    logic [N_CHAN*PD_W-1:0]   pd_o [3];
    logic                     ref_o [3];
    logic                     exec_o [3];
    logic [1:0]               strap [3];
    logic [15:0]              mb [3][4];
    logic [15:0]              mr [3][4];
    int                       refm [3];
    int                       fail_count, num_checks;
    int                       nexec [3] = '{0, 0, 0};
    int                       mexec [3] = '{0, 0, 0};

    qdc_if link();
    qdc_if link_f();

    // ==================== Design ====================
    qdc_host u_qdc_host (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .link(link), .i_start(start),
        .i_word(word), .o_busy(busy), .o_done(done));
    qdc_dev u_qdc_dev (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .link(link), .i_addr_pin_hi(strap[0][1]),
        .i_addr_pin_lo(strap[0][0]), .o_dac_code(code_o[0]), .o_chan_pd(pd_o[0]), .o_ref_on(ref_o[0]),
        .o_cmd_exec(exec_o[0]));
    qdc_dev u_qdc_dev_b (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .link(link), .i_addr_pin_hi(strap[1][1]),
        .i_addr_pin_lo(strap[1][0]), .o_dac_code(code_o[1]), .o_chan_pd(pd_o[1]), .o_ref_on(ref_o[1]),
        .o_cmd_exec(exec_o[1]));
    qdc_dev u_qdc_dev_f (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .link(link_f), .i_addr_pin_hi(strap[2][1]),
        .i_addr_pin_lo(strap[2][0]), .o_dac_code(code_o[2]), .o_chan_pd(pd_o[2]), .o_ref_on(ref_o[2]),
        .o_cmd_exec(exec_o[2]));
    qdc_link_chk u_qdc_link_chk (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .frame_sel_n(link.frame_sel_n),
        .sclk(link.sclk), .sdata(link.sdata), .o_busy(busy), .o_done(done), .o_cmd_exec(exec_o[0]),
        .o_dac_code(code_o[0]));

    // ==================== Helpers ====================
    // Clock generator
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Count command pulses of each converter
    always @(posedge clk_sys) begin
        for (int d = 0; d < 3; d++) begin
            if (exec_o[d] === 1'b1) nexec[d]++;
        end
    end

    function automatic logic [23:0] mk(logic [1:0] a, logic [1:0] ld, logic [1:0] sel, logic pd,
                                       logic [13:0] dat);
        return {a, ld, 1'b0, sel, pd, dat, 2'h3};
    endfunction

    // Expected buffers and converter registers of one converter
    task automatic model(int d, logic [23:0] w);
        logic [15:0] e;
        logic        hit;
        hit = (w[23:22] == strap[d]) || (w[21:20] == LD_BCAST);
        if (hit) mexec[d]++;
        if (hit && (w == CMD_REF_OFF || w == CMD_REF_ON || w == CMD_REF_AUTO)) begin
            refm[d] = (w == CMD_REF_OFF) ? 1 : (w == CMD_REF_ON) ? 2 : 0;
            return;
        end
        if (!hit) return;
        for (int c = 0; c < 4; c++) begin
            e = w[16] ? {w[15:14], mb[d][c][13:0]} : {2'b00, w[15:2]};
            if (w[21:20] == LD_BCAST) begin
                if (w[18]) mb[d][c] = e;
                mr[d][c] = mb[d][c];
            end else begin
                if (c == w[18:17]) mb[d][c] = e;
                if ((c == w[18:17] && w[21:20] == LD_UPDATE) || w[21:20] == LD_SIMUL) mr[d][c] = mb[d][c];
            end
        end
    endtask

    task automatic check_all();
        logic er;
        for (int d = 0; d < 3; d++) begin
            er = (refm[d] == 2);
            for (int c = 0; c < 4; c++) begin
                `QDC_CHK("code", mr[d][c][13:0], code_o[d][c*DATA_W +: DATA_W])
                `QDC_CHK("mode", mr[d][c][15:14], pd_o[d][c*PD_W +: PD_W])
                if (mr[d][c][15:14] == PD_ACTIVE && refm[d] == 0) er = 1'b1;
            end
            `QDC_CHK("ref", er, ref_o[d])
            `QDC_CHK("exec", mexec[d], nexec[d])
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One frame through the host end, bounded wait for done
    task automatic send(logic [23:0] w);
        int n;
        start <= 1'b1;
        word  <= w;
        @(posedge clk_sys);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (done !== 1'b1 && n < 400);
        if (n >= 400) begin
            fail_count++;
            give_verdict();
        end
        model(0, w);
        model(1, w);
        repeat (2) @(posedge clk_sys);
        check_all();
    endtask

    // Hand-driven frame of nb bits on the second link; bits past 24 are inverted
    task automatic raw(logic [23:0] w, int nb);
        link_f.frame_sel_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < nb; i++) begin
            link_f.sdata <= w[23 - (i % 24)] ^ (i >= 24);
            link_f.sclk  <= 1'b1;
            repeat (4) @(posedge clk_sys);
            link_f.sclk  <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        link_f.frame_sel_n <= 1'b1;
        link_f.sdata       <= ~link_f.sdata;
        repeat (20) @(posedge clk_sys);
        if (nb >= 24) model(2, w);
        check_all();
    endtask

    // ==================== Sequence ====================
    initial begin
        strap[0] = 2'h0;
        strap[1] = 2'h1;
        strap[2] = 2'h0;
        start = 1'b0;
        word = '0;
        rst_n = 1'b0;
        link_f.frame_sel_n = 1'b1;
        link_f.sclk = 1'b0;
        link_f.sdata = 1'b0;
        fail_count = 0;
        num_checks = 0;
        foreach (mb[d, c]) begin
            mb[d][c] = '0;
            mr[d][c] = '0;
        end
        foreach (refm[d]) refm[d] = 0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check_all();
        for (int c = 0; c < 4; c++) begin
            send(mk(2'h0, LD_STORE, 2'(c), 1'b0, 14'h1555 + 14'(c)));
        end
        send(mk(2'h0, LD_SIMUL, 2'h3, 1'b0, 14'h3fff));
        send(mk(2'h1, LD_UPDATE, 2'h1, 1'b0, 14'h0001));
        send(mk(2'h0, LD_UPDATE, 2'h2, 1'b1, 14'h3000));
        send(mk(2'h0, LD_BCAST, 2'h2, 1'b0, 14'h02a5));
        send(mk(2'h1, LD_STORE, 2'h0, 1'b0, 14'h0abc));
        send(mk(2'h0, LD_STORE, 2'h1, 1'b0, 14'h1234));
        send(mk(2'h3, LD_BCAST, 2'h0, 1'b0, 14'h3fff));
        send(mk(2'h0, LD_BCAST, 2'h3, 1'b1, 14'h1000));
        send(CMD_REF_ON);
        send(CMD_REF_OFF);
        send(CMD_REF_AUTO);
        send(mk(2'h0, LD_UPDATE, 2'h0, 1'b0, 14'h0010));
        raw(mk(2'h0, LD_UPDATE, 2'h1, 1'b0, 14'h0777), 10);
        raw(mk(2'h0, LD_UPDATE, 2'h1, 1'b0, 14'h0777), 28);
        raw(mk(2'h0, LD_UPDATE, 2'h2, 1'b0, 14'h0555), 23);
        give_verdict();
    end
endmodule
